// *** verilog/tpr_raster_ctrl.sv ***
// Raster timing controller that drives the pixel clock, syncs, colour data and display-on of a TFT panel.
`timescale 1ns/1ns
`default_nettype none
module tpr_raster_ctrl
  import tpr_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          enable,
  input  wire logic          analog_supply_good,
  input  wire tpr_pkg::tpr_pixel_type pixel_in,
  output logic               pixel_req,
  output logic [COL_W-1:0]   pixel_col,
  output logic [ROW_W-1:0]   pixel_row,
  output tpr_pkg::tpr_panel_type panel,
  output logic               image_valid,
  output logic               timing_active,
  output logic               frame_start
);
  import tpr_pkg::*;

  logic                 supply_ok;
  logic [PIX_DIV_W-1:0] div_q;
  logic [PIX_DIV_W-1:0] div_d;
  logic                 pclk_q;
  logic                 pclk_d;
  logic                 fall;
  logic [COL_W-1:0]     col_q;
  logic [COL_W-1:0]     col_d;
  logic [ROW_W-1:0]     row_q;
  logic [ROW_W-1:0]     row_d;
  logic                 hsync_n_q;
  logic                 hsync_n_d;
  logic                 vsync_n_q;
  logic                 vsync_n_d;
  tpr_pixel_type        pix_q;
  tpr_pixel_type        pix_d;
  logic                 col_vis;
  logic                 row_vis;
  logic                 visible;
  logic                 frame_end;
  tpr_state_type        state_q;
  tpr_state_type        state_d;
  logic [FCNT_W-1:0]    fcnt_q;
  logic [FCNT_W-1:0]    fcnt_d;
  logic                 disp_q;
  logic                 disp_d;
  logic                 run_q;
  logic                 run_d;

  // The analog supply status is a pin from the power circuit, so it is synchronised.
  tpr_sync_in u_supply_sync
  (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .async_in  (analog_supply_good),
    .level_out (supply_ok)
  );

  // Pixel clock made by dividing the reference clock; syncs and colour data move on its falling edge, display-on can drop on any reference clock.
  always_comb
  begin
    div_d  = div_q;
    pclk_d = pclk_q;
    fall   = 1'b0;
    if (run_q)
    begin
      div_d = (div_q == PIX_DIV_LAST) ? '0 : div_q + 1'b1;
      if (div_q == PIX_DIV_LAST)
      begin
        pclk_d = 1'b0;
        fall   = 1'b1;
      end
      else if (div_q == PIX_DIV_RISE)
      begin
        pclk_d = 1'b1;
      end
    end
    else
    begin
      div_d  = '0;
      pclk_d = 1'b0;
    end
  end

  // Raster counters; column 0 is the first clock of the line sync pulse.
  assign col_vis   = (col_q >= COL_VIS_START) && (col_q < COL_VIS_END);
  assign row_vis   = (row_q >= ROW_VIS_START) && (row_q < ROW_VIS_END);
  assign visible   = col_vis && row_vis;
  assign frame_end = fall && (col_q == COL_LAST) && (row_q == ROW_LAST);

  always_comb
  begin
    col_d     = col_q;
    row_d     = row_q;
    hsync_n_d = hsync_n_q;
    vsync_n_d = vsync_n_q;
    pix_d     = pix_q;
    if (!run_q)
    begin
      col_d     = '0;
      row_d     = '0;
      hsync_n_d = 1'b1;
      vsync_n_d = 1'b1;
      pix_d     = '0;
    end
    else if (fall)
    begin
      hsync_n_d = !(col_q < COL_SYNC_END);
      vsync_n_d = !(row_q < ROW_SYNC_END);
      pix_d     = visible ? pixel_in : '0;
      if (col_q == COL_LAST)
      begin
        col_d = '0;
        row_d = (row_q == ROW_LAST) ? '0 : row_q + 1'b1;
      end
      else
      begin
        col_d = col_q + 1'b1;
      end
    end
  end

  // Power sequencing of display-on against the running raster.
  always_comb
  begin
    state_d = state_q;
    fcnt_d  = fcnt_q;
    disp_d  = disp_q;
    run_d   = run_q;
    unique case (state_q)
      ST_OFF:
      begin
        disp_d = 1'b0;
        if (enable && supply_ok)
        begin
          run_d   = 1'b1;
          state_d = ST_ARM;
        end
        else
        begin
          run_d = 1'b0;
        end
      end
      ST_ARM:
      begin
        // Raise display-on only at a frame boundary, where frame sync is high.
        if (!enable || !supply_ok)
        begin
          state_d = ST_OFF;
        end
        else if (frame_end && vsync_n_q)
        begin
          disp_d  = 1'b1;
          fcnt_d  = '0;
          state_d = ST_STARTING;
        end
      end
      ST_STARTING:
      begin
        if (!enable || !supply_ok)
        begin
          disp_d  = 1'b0;
          fcnt_d  = '0;
          state_d = ST_STOPPING;
        end
        else if (frame_end)
        begin
          fcnt_d = fcnt_q + 1'b1;
          if (fcnt_q == START_LAST)
          begin
            state_d = ST_ON;
          end
        end
      end
      ST_ON:
      begin
        if (!enable || !supply_ok)
        begin
          disp_d  = 1'b0;
          fcnt_d  = '0;
          state_d = ST_STOPPING;
        end
      end
      ST_STOPPING:
      begin
        // Timing keeps running after display-on drops so the panel can discharge.
        if (frame_end)
        begin
          fcnt_d = fcnt_q + 1'b1;
          if (fcnt_q == STOP_LAST)
          begin
            run_d   = 1'b0;
            state_d = ST_OFF;
          end
        end
      end
      default:
      begin
        state_d = ST_OFF;
        disp_d  = 1'b0;
        run_d   = 1'b0;
      end
    endcase
    if (!supply_ok)
    begin
      disp_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q     <= '0;
      pclk_q    <= 1'b0;
      col_q     <= '0;
      row_q     <= '0;
      hsync_n_q <= 1'b1;
      vsync_n_q <= 1'b1;
      pix_q     <= '0;
      state_q   <= ST_OFF;
      fcnt_q    <= '0;
      disp_q    <= 1'b0;
      run_q     <= 1'b0;
    end
    else
    begin
      div_q     <= div_d;
      pclk_q    <= pclk_d;
      col_q     <= col_d;
      row_q     <= row_d;
      hsync_n_q <= hsync_n_d;
      vsync_n_q <= vsync_n_d;
      pix_q     <= pix_d;
      state_q   <= state_d;
      fcnt_q    <= fcnt_d;
      disp_q    <= disp_d;
      run_q     <= run_d;
    end
  end

  // All panel pins are plain outputs driven from flip-flops at all times.
  assign panel.pixel_clock  = pclk_q;
  assign panel.line_sync_n  = hsync_n_q;
  assign panel.frame_sync_n = vsync_n_q;
  assign panel.display_on   = disp_q;
  assign panel.pixel        = pix_q;

  assign pixel_req     = fall && visible;
  assign pixel_col     = col_q;
  assign pixel_row     = row_q;
  assign image_valid   = (state_q == ST_ON);
  assign timing_active = run_q;
  assign frame_start   = frame_end;
endmodule
`default_nettype wire

// *** pkg/tpr_pkg.sv ***
// Package with raster geometry, timing constants and carrier types for the panel timing controller.
`default_nettype none
package tpr_pkg;
  localparam int unsigned REF_CLK_HZ        = 25000000;
  localparam int unsigned PIX_CLK_HZ        = 9000000;
  localparam int unsigned PIX_CLK_MIN_HZ    = 7830000;
  localparam int unsigned PIX_CLK_MAX_HZ    = 9260000;
  // Divider that makes the pixel clock; 25 MHz / 3 = 8.33 MHz lies inside the allowed band.
  // Rounded up so the divided clock never runs above the nominal rate.
  localparam int unsigned PIX_DIV           = (REF_CLK_HZ + PIX_CLK_HZ - 1) / PIX_CLK_HZ;
  localparam int unsigned PIX_DIV_HIGH      = PIX_DIV / 2;
  localparam int unsigned PIX_DIV_W         = 2;
  localparam logic [PIX_DIV_W-1:0] PIX_DIV_LAST = PIX_DIV_W'(PIX_DIV - 1);
  localparam logic [PIX_DIV_W-1:0] PIX_DIV_RISE = PIX_DIV_W'(PIX_DIV_HIGH);

  localparam int unsigned LINE_TOTAL        = 525;
  localparam int unsigned LINE_SYNC_WIDTH   = 41;
  localparam int unsigned LINE_BACK_PORCH   = 2;
  localparam int unsigned LINE_VISIBLE_CLOCKS = 480;
  localparam int unsigned LINE_FRONT_PORCH  = 2;
  localparam int unsigned FRAME_TOTAL       = 286;
  localparam int unsigned FRAME_SYNC_WIDTH  = 10;
  localparam int unsigned FRAME_BACK_PORCH  = 2;
  localparam int unsigned FRAME_VISIBLE_LINES = 272;
  localparam int unsigned FRAME_FRONT_PORCH = 2;
  localparam int unsigned START_FRAMES      = 10;
  localparam int unsigned STOP_FRAMES       = 10;

  localparam int unsigned COL_W   = 10;
  localparam int unsigned ROW_W   = 9;
  localparam int unsigned FCNT_W  = 4;
  localparam int unsigned CHAN_W  = 8;

  localparam logic [COL_W-1:0] COL_LAST      = COL_W'(LINE_TOTAL - 1);
  localparam logic [COL_W-1:0] COL_SYNC_END  = COL_W'(LINE_SYNC_WIDTH);
  localparam logic [COL_W-1:0] COL_VIS_START = COL_W'(LINE_SYNC_WIDTH + LINE_BACK_PORCH);
  localparam logic [COL_W-1:0] COL_VIS_END   = COL_W'(LINE_SYNC_WIDTH + LINE_BACK_PORCH + LINE_VISIBLE_CLOCKS);
  localparam logic [ROW_W-1:0] ROW_LAST      = ROW_W'(FRAME_TOTAL - 1);
  localparam logic [ROW_W-1:0] ROW_SYNC_END  = ROW_W'(FRAME_SYNC_WIDTH);
  localparam logic [ROW_W-1:0] ROW_VIS_START = ROW_W'(FRAME_SYNC_WIDTH + FRAME_BACK_PORCH);
  localparam logic [ROW_W-1:0] ROW_VIS_END   = ROW_W'(FRAME_SYNC_WIDTH + FRAME_BACK_PORCH + FRAME_VISIBLE_LINES);
  localparam logic [FCNT_W-1:0] START_LAST   = FCNT_W'(START_FRAMES - 1);
  localparam logic [FCNT_W-1:0] STOP_LAST    = FCNT_W'(STOP_FRAMES - 1);

  typedef struct packed {
    logic [CHAN_W-1:0] red_bits;
    logic [CHAN_W-1:0] green_bits;
    logic [CHAN_W-1:0] blue_bits;
  } tpr_pixel_type;

  typedef struct packed {
    logic          pixel_clock;
    logic          line_sync_n;
    logic          frame_sync_n;
    logic          display_on;
    tpr_pixel_type pixel;
  } tpr_panel_type;

  typedef enum logic [4:0] {
    ST_OFF      = 5'h01,
    ST_ARM      = 5'h02,
    ST_STARTING = 5'h04,
    ST_ON       = 5'h08,
    ST_STOPPING = 5'h10
  } tpr_state_type;
endpackage
`default_nettype wire

// *** verilog/tpr_sync_in.sv ***
// Three-stage synchroniser for a level that arrives from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module tpr_sync_in
  import tpr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;

  // The level moves only when the second and third stage agree.
  always_comb
  begin
    level_d = level_q;
    if (s2_q == s3_q)
    begin
      level_d = s3_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule
`default_nettype wire

// *** tb/tpr_raster_sva.sv ***
// Assertion checker for the raster timing controller, bound to its ports.
`timescale 1ns/1ns
`default_nettype none
module tpr_raster_sva
  import tpr_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic                   enable,
  input wire logic                   analog_supply_good,
  input wire tpr_pkg::tpr_pixel_type pixel_in,
  input wire logic                   pixel_req,
  input wire logic [COL_W-1:0]       pixel_col,
  input wire logic [ROW_W-1:0]       pixel_row,
  input wire tpr_pkg::tpr_panel_type panel,
  input wire logic                   image_valid,
  input wire logic                   timing_active,
  input wire logic                   frame_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Sync widths run to hundreds of cycles, so they are counted here rather than unrolled.
  logic        ls_q;
  logic        fs_q;
  logic        seen_q;
  logic        seen_d;
  logic        ls_fall;
  logic        fs_fall;
  logic [7:0]  hs_q;
  logic [7:0]  hs_d;
  logic [10:0] ln_q;
  logic [10:0] ln_d;
  logic [3:0]  fl_q;
  logic [3:0]  fl_d;
  always_comb
  begin
    ls_fall = ls_q & ~panel.line_sync_n;
    fs_fall = fs_q & ~panel.frame_sync_n;
    hs_d = panel.line_sync_n ? 8'h00 : hs_q + 8'h01;
    ln_d = ls_fall ? 11'h000 : ln_q + 11'h001;
    seen_d = seen_q | ls_fall;
    fl_d = fs_fall ? 4'h1 : ((ls_fall & ~panel.frame_sync_n) ? fl_q + 4'h1 : fl_q);
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ls_q <= 1'b1;
      fs_q <= 1'b1;
      seen_q <= 1'b0;
      hs_q <= 8'h00;
      ln_q <= 11'h000;
      fl_q <= 4'h0;
    end
    else
    begin
      ls_q <= panel.line_sync_n;
      fs_q <= panel.frame_sync_n;
      seen_q <= seen_d;
      hs_q <= hs_d;
      ln_q <= ln_d;
      fl_q <= fl_d;
    end
  end
  sequence s_gap;
    (!$rose(panel.pixel_clock)) [*2];
  endsequence
  sequence s_porch;
    (panel.pixel == 24'h0) [*6];
  endsequence
  property p_pclk_period;
    $rose(panel.pixel_clock) |=> s_gap ##1 ($rose(panel.pixel_clock) || !timing_active);
  endproperty
  a_pclk_period: assert property (p_pclk_period) else $error("pixel clock period wrong");
  property p_sync_width;
    $rose(panel.line_sync_n) && timing_active |-> hs_q == 8'(3 * LINE_SYNC_WIDTH);
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("line sync width wrong");
  property p_line_len;
    ls_fall && seen_q |-> ln_q == 11'(3 * LINE_TOTAL - 1);
  endproperty
  a_line_len: assert property (p_line_len) else $error("line length wrong");
  property p_blank;
    !panel.line_sync_n || !panel.frame_sync_n |-> panel.pixel == 24'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("colour data during sync");
  property p_porch;
    $rose(panel.line_sync_n) |-> s_porch;
  endproperty
  a_porch: assert property (p_porch) else $error("back porch not blank");
  property p_fs_width;
    $rose(panel.frame_sync_n) && timing_active |-> fl_q == 4'(FRAME_SYNC_WIDTH);
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame sync width wrong");
  property p_dispon;
    $rose(panel.display_on) |-> panel.frame_sync_n;
  endproperty
  a_dispon: assert property (p_dispon) else $error("display on rose in frame sync");
  property p_supply;
    (!analog_supply_good) [*6] |-> !panel.display_on;
  endproperty
  a_supply: assert property (p_supply) else $error("display on without supply");
  property p_take;
    pixel_req |=> panel.pixel == $past(pixel_in);
  endproperty
  a_take: assert property (p_take) else $error("pixel not passed through");
  property p_edge;
    timing_active && $past(timing_active) && $changed({panel.line_sync_n, panel.frame_sync_n, panel.pixel})
      |-> $fell(panel.pixel_clock);
  endproperty
  a_edge: assert property (p_edge) else $error("output moved off clock fall");
endmodule
bind tpr_raster_ctrl tpr_raster_sva i_sva (.ref_clk(ref_clk), .reset_n(reset_n), .enable(enable),
  .analog_supply_good(analog_supply_good), .pixel_in(pixel_in), .pixel_req(pixel_req), .pixel_col(pixel_col),
  .pixel_row(pixel_row), .panel(panel), .image_valid(image_valid), .timing_active(timing_active),
  .frame_start(frame_start));
`default_nettype wire

// *** tb/tpr_panel_model.sv ***
// Behavioural panel model that samples the raster on pixel clock rises.
`timescale 1ns/1ns
`default_nettype none
module tpr_panel_model
  import tpr_pkg::*;
(
  input  wire tpr_pkg::tpr_panel_type panel,
  output int                          col,
  output int                          line_clocks,
  output int                          sync_clocks,
  output int                          sync_lines,
  output int                          period_ns,
  output logic                        image_shown
);
  int   row;
  int   frames;
  time  t_last;
  logic ls_q;
  logic fs_q;
  initial
  begin
    col = 0;
    row = 0;
    frames = 0;
    t_last = 0;
    ls_q = 1'b1;
    fs_q = 1'b1;
    image_shown = 1'b0;
  end
  always @(posedge panel.pixel_clock)
  begin
    period_ns = int'($time - t_last);
    t_last = $time;
    col = col + 1;
    if (!ls_q && panel.line_sync_n)
      sync_clocks = col;
    if (ls_q && !panel.line_sync_n)
    begin
      line_clocks = col;
      col = 0;
      row = (fs_q && !panel.frame_sync_n) ? 0 : row + 1;
    end
    if (!fs_q && panel.frame_sync_n)
      sync_lines = row;
    // The image appears only after the internal boost has run for its frames.
    if (fs_q && !panel.frame_sync_n)
      frames = panel.display_on ? frames + 1 : 0;
    image_shown = (frames >= START_FRAMES);
    ls_q = panel.line_sync_n;
    fs_q = panel.frame_sync_n;
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench for the raster timing controller with a panel model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %0h expected %0h", $time, a, e); end end
module tb_top;
  import tpr_pkg::*;
  logic             ref_clk;
  logic             reset_n;
  logic             enable;
  logic             analog_supply_good;
  logic             corner;
  tpr_pixel_type    pixel_in;
  tpr_pixel_type    exp_px;
  logic             pixel_req;
  logic [COL_W-1:0] pixel_col;
  logic [ROW_W-1:0] pixel_row;
  tpr_panel_type    panel;
  logic             image_valid;
  logic             timing_active;
  logic             frame_start;
  logic             image_shown;
  tpr_pixel_type    q[$];
  int               col, line_clocks, sync_clocks, sync_lines, period_ns;
  int               mismatches, num_checks, cycles, pops, n;
  tpr_raster_ctrl i_tpr_raster_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .enable(enable),
    .analog_supply_good(analog_supply_good), .pixel_in(pixel_in), .pixel_req(pixel_req), .pixel_col(pixel_col),
    .pixel_row(pixel_row), .panel(panel), .image_valid(image_valid), .timing_active(timing_active),
    .frame_start(frame_start));
  tpr_panel_model i_tpr_panel_model (.panel(panel), .col(col), .line_clocks(line_clocks),
    .sync_clocks(sync_clocks), .sync_lines(sync_lines), .period_ns(period_ns), .image_shown(image_shown));
  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    // The corner pattern sets only the top bit of red, every bit of green and only the bottom bit of blue.
    pixel_in <= corner ? 24'h80ff01 : 24'($urandom());
    if (pixel_req)
      q.push_back(pixel_in);
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      final_report();
    end
  end
  always @(posedge panel.pixel_clock)
  begin
    #1;
    if (col >= int'(COL_VIS_START) && col < int'(COL_VIS_END) && q.size() > 0)
    begin
      exp_px = q.pop_front();
      pops++;
      `CHK(panel.pixel, exp_px)
    end
    else
      `CHK(panel.pixel, 24'h0)
  end
  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    enable = 1'b0;
    analog_supply_good = 1'b0;
    corner = 1'b0;
    pixel_in = '0;
    void'($urandom(32'h744f));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(panel, {1'b0, 1'b1, 1'b1, 1'b0, 24'h0})
    test_end("reset");
    @(posedge ref_clk);
    enable <= 1'b1;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(panel.display_on, 1'b0)
    `CHK(timing_active, 1'b0)
    test_end("supply_down");
    @(posedge ref_clk);
    analog_supply_good <= 1'b1;
    n = 0;
    while (timing_active !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(timing_active, 1'b1)
    repeat (13 * 3 * LINE_TOTAL) @(posedge ref_clk);
    corner <= 1'b1;
    repeat (2 * 3 * LINE_TOTAL) @(posedge ref_clk);
    corner <= 1'b0;
    repeat (5 * 3 * LINE_TOTAL) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(line_clocks, LINE_TOTAL)
    `CHK(sync_clocks, LINE_SYNC_WIDTH)
    `CHK(sync_lines, FRAME_SYNC_WIDTH)
    `CHK(period_ns >= 108 && period_ns <= 128, 1'b1)
    `CHK(pops >= LINE_VISIBLE_CLOCKS, 1'b1)
    `CHK(panel.display_on, 1'b0)
    `CHK(image_valid, 1'b0)
    `CHK(image_shown, 1'b0)
    test_end("raster");
    @(posedge ref_clk);
    enable <= 1'b0;
    repeat (3 * LINE_TOTAL) @(posedge ref_clk);
    @(negedge ref_clk);
    // Display-on never rose in this short run, so the raster stops without a discharge tail.
    `CHK(panel.display_on, 1'b0)
    `CHK(timing_active, 1'b0)
    @(posedge ref_clk);
    analog_supply_good <= 1'b0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(panel.display_on, 1'b0)
    `CHK(timing_active, 1'b0)
    test_end("shutdown");
    final_report();
  end
endmodule
`default_nettype wire
